// *** inc/uic_cfg.svh ***
// Register map, field positions and reset values for the interrupt and queue control block
`ifndef UIC_CFG_SVH
`define UIC_CFG_SVH
`define UIC_ADDR_IER 12'h000
`define UIC_ADDR_ISR 12'h004
`define UIC_ADDR_FCR 12'h008
`define UIC_ADDR_FEATURE_CONTROL_REG 12'h00C
`define UIC_ADDR_EFR 12'h010
`define UIC_ADDR_MCR 12'h014
`define UIC_ADDR_EVT 12'h018
`define UIC_ADDR_STAT 12'h01C
`define UIC_IER_RX 0
`define UIC_IER_TX 1
`define UIC_IER_LS 2
`define UIC_IER_MS 3
`define UIC_IER_XOFF 5
`define UIC_IER_RTS 6
`define UIC_IER_CTS 7
`define UIC_FCR_EN 0
`define UIC_FCR_RXRST 1
`define UIC_FCR_TXRST 2
`define UIC_FCR_DMA 3
`define UIC_FEATURE_CONTROL_REG_RS485 5
`define UIC_EFR_ENH 4
`define UIC_EFR_AUTORTS 6
`define UIC_EFR_AUTOCTS 7
`define UIC_MCR_DTRSEL 2
`define UIC_CODE_LS 6'h06
`define UIC_CODE_RXD 6'h04
`define UIC_CODE_RXTO 6'h0C
`define UIC_CODE_TX 6'h02
`define UIC_CODE_MS 6'h00
`define UIC_CODE_SPC 6'h10
`define UIC_CODE_PIN 6'h20
`define UIC_CODE_NONE 6'h01
`define UIC_TO_CHARS 8'h04
`define UIC_TO_BITS 8'h0C
`define UIC_BITS_PER_CHAR 8'h0A
`define UIC_LVL_DEFAULT 9'h001
`endif

// *** inc/uic_pkg.sv ***
// Types shared by the interrupt and queue control block
package uic_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } uic_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } uic_apb_rsp_t;
  // Events and levels from the surrounding channel datapath
  typedef struct packed {
    logic rxErrArrive;
    logic rxHeadErr;
    logic rxFifoHasErr;
    logic rxHoldFull;
    logic [8:0] rxCount;
    logic rxCharDone;
    logic [8:0] txCount;
    logic txShiftEmpty;
    logic txLoaded;
    logic [3:0] modemDelta;
    logic specialChar;
    logic ctsLine;
    logic dsrLine;
    logic rtsLine;
    logic dtrLine;
    logic wakeUp;
    logic bitTick;
  } uic_chan_t;
  // Host accesses seen beside the block's own registers
  typedef struct packed {
    logic lsrRead;
    logic msrRead;
    logic rhrRead;
    logic thrWrite;
    logic globalRead;
  } uic_host_t;
  typedef enum logic [1:0] {TO_IDLE = 2'b00, TO_RUN = 2'b01, TO_FIRE = 2'b11} uic_to_state_t;
endpackage

// *** logic/uic_trigger_lut.sv ***
// Trigger table lookup for receive and transmit levels
`timescale 1ns/100ps
`include "uic_cfg.svh"
module uic_trigger_lut import uic_pkg::*; (
  // Selection
  input wire logic [1:0] tableSel,
  input wire logic [1:0] rxSel,
  input wire logic [1:0] txSel,
  input wire logic enhanced,
  input wire logic [8:0] rxProg,
  input wire logic [8:0] txProg,
  // Levels
  output logic [8:0] rxLevel,
  output logic [8:0] txLevel
);
  always_comb begin
    rxLevel = `UIC_LVL_DEFAULT;
    txLevel = `UIC_LVL_DEFAULT;
    case (tableSel)
      2'b00: begin
        case (rxSel)
          2'b00: rxLevel = 9'h001;
          2'b01: rxLevel = 9'h004;
          2'b10: rxLevel = 9'h008;
          default: rxLevel = 9'h00E;
        endcase
      end
      2'b01: begin
        case (rxSel)
          2'b00: rxLevel = 9'h008;
          2'b01: rxLevel = 9'h010;
          2'b10: rxLevel = 9'h018;
          default: rxLevel = 9'h01C;
        endcase
        case (txSel)
          2'b00: txLevel = 9'h010;
          2'b01: txLevel = 9'h008;
          2'b10: txLevel = 9'h018;
          default: txLevel = 9'h01E;
        endcase
      end
      2'b10: begin
        case (rxSel)
          2'b00: rxLevel = 9'h008;
          2'b01: rxLevel = 9'h010;
          2'b10: rxLevel = 9'h038;
          default: rxLevel = 9'h03C;
        endcase
        case (txSel)
          2'b00: txLevel = 9'h008;
          2'b01: txLevel = 9'h010;
          2'b10: txLevel = 9'h020;
          default: txLevel = 9'h038;
        endcase
      end
      default: begin
        rxLevel = rxProg;
        txLevel = txProg;
      end
    endcase
    if (!enhanced) begin
      txLevel = `UIC_LVL_DEFAULT;
    end
  end
endmodule

// *** logic/uic_irq_ctrl.sv ***
// Interrupt prioritiser and queue control for one channel, APB slave
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "uic_cfg.svh"
module uic_irq_ctrl import uic_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // APB
  input wire uic_apb_req_t apbReq,
  output uic_apb_rsp_t apbRsp,
  // Channel datapath
  input wire uic_chan_t chan,
  input wire uic_host_t host,
  // Controls to datapath
  output logic fifoEnable,
  output logic txFifoReset,
  output logic rxFifoReset,
  output logic [8:0] rxTrigLevel,
  output logic [8:0] txTrigLevel,
  output logic [7:0] lineErrFlags,
  // Interrupt request and wake-up
  output logic irqOut,
  output logic globalIrqSummary
);
  typedef struct packed {
    logic [7:0] irq_enable_mask;
    logic fifoEn;
    logic dma;
    logic [1:0] rxSel;
    logic [1:0] txSel;
    logic [1:0] trigTable;
    logic [7:0] feature_control_reg;
    logic [7:0] enhanced_function_reg;
    logic [7:0] modem_control_reg;
    logic [8:0] rxProg;
    logic [8:0] txProg;
    logic txRst;
    logic rxRst;
    logic lsPend;
    logic headSeen;
    logic txPend;
    logic txBelowDone;
    logic txEmptyDone;
    logic txOver;
    logic msPend;
    logic spPend;
    logic pinPend;
    logic wake;
    logic [3:0] pinPrev;
    uic_to_state_t toState;
    logic [7:0] toBits;
    logic toPend;
    logic [31:0] rdata;
    logic [7:0] lsrView;
  } uic_state_t;

  uic_state_t stateReg;
  uic_state_t stateNext;
  logic [8:0] rxLvl;
  logic [8:0] txLvl;
  logic rxDataPending;
  logic [5:0] code;
  logic anyPending;
  logic setupRd;
  logic setupWr;
  logic isrRead;
  logic txEmptyNow;
  logic [3:0] pinNow;
  logic [3:0] pinRise;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ref_a);
    hit = (a == ref_a);
  endfunction

  uic_trigger_lut lut (
    .tableSel(stateReg.trigTable),
    .rxSel(stateReg.rxSel),
    .txSel(stateReg.txSel),
    .enhanced(stateReg.enhanced_function_reg[`UIC_EFR_ENH]),
    .rxProg(stateReg.rxProg),
    .txProg(stateReg.txProg),
    .rxLevel(rxLvl),
    .txLevel(txLvl)
  );

  // Zero wait states: the access phase completes in its first cycle
  assign setupRd = apbReq.psel & apbReq.penable & ~apbReq.pwrite;
  assign setupWr = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign isrRead = setupRd & hit(apbReq.paddr, `UIC_ADDR_ISR);

  assign rxDataPending = stateReg.fifoEn ? (chan.rxCount >= rxLvl) : chan.rxHoldFull;
  assign txEmptyNow = (chan.txCount == 9'h000) &
    (~stateReg.feature_control_reg[`UIC_FEATURE_CONTROL_REG_RS485] | chan.txShiftEmpty);
  // Both pin pairs, cts/rts and dsr/dtr; the MCR select bit picks one below
  assign pinNow = {chan.rtsLine, chan.ctsLine, chan.dtrLine, chan.dsrLine};
  assign pinRise = pinNow & ~stateReg.pinPrev;

  // Priority encoder over enabled sources
  always_comb begin
    code = `UIC_CODE_NONE;
    if (stateReg.pinPend) code = `UIC_CODE_PIN;
    if (stateReg.spPend && stateReg.irq_enable_mask[`UIC_IER_XOFF]) code = `UIC_CODE_SPC;
    if (stateReg.msPend && stateReg.irq_enable_mask[`UIC_IER_MS]) code = `UIC_CODE_MS;
    if (stateReg.txPend && stateReg.irq_enable_mask[`UIC_IER_TX]) code = `UIC_CODE_TX;
    if (stateReg.toPend && stateReg.irq_enable_mask[`UIC_IER_RX]) code = `UIC_CODE_RXTO;
    if (rxDataPending && stateReg.irq_enable_mask[`UIC_IER_RX]) code = `UIC_CODE_RXD;
    if (stateReg.lsPend && stateReg.irq_enable_mask[`UIC_IER_LS]) code = `UIC_CODE_LS;
  end
  assign anyPending = (code != `UIC_CODE_NONE);

  always_comb begin
    logic dtrSel;
    logic pinHit;
    logic topServed;
    dtrSel = stateReg.modem_control_reg[`UIC_MCR_DTRSEL];
    pinHit = 1'b0;
    topServed = 1'b0;
    stateNext = stateReg;
    stateNext.txRst = 1'b0;
    stateNext.rxRst = 1'b0;
    stateNext.pinPrev = pinNow;

    // Register writes
    if (setupWr) begin
      case (apbReq.paddr)
        `UIC_ADDR_IER: stateNext.irq_enable_mask = apbReq.pwdata[7:0];
        `UIC_ADDR_FCR: begin
          stateNext.fifoEn = apbReq.pwdata[`UIC_FCR_EN];
          if (apbReq.pwdata[`UIC_FCR_EN]) begin
            stateNext.dma = apbReq.pwdata[`UIC_FCR_DMA];
            stateNext.rxSel = apbReq.pwdata[7:6];
            stateNext.txSel = apbReq.pwdata[5:4];
            stateNext.txRst = apbReq.pwdata[`UIC_FCR_TXRST];
            stateNext.rxRst = apbReq.pwdata[`UIC_FCR_RXRST];
          end
        end
        `UIC_ADDR_FEATURE_CONTROL_REG: begin
          stateNext.feature_control_reg = apbReq.pwdata[7:0];
          stateNext.trigTable = apbReq.pwdata[7:6];
        end
        `UIC_ADDR_EFR: stateNext.enhanced_function_reg = apbReq.pwdata[7:0];
        `UIC_ADDR_MCR: stateNext.modem_control_reg = apbReq.pwdata[7:0];
        `UIC_ADDR_EVT: begin
          stateNext.rxProg = apbReq.pwdata[8:0];
          stateNext.txProg = apbReq.pwdata[24:16];
        end
        default: ;
      endcase
    end

    // Line status: clears on line read, set wins
    if (host.lsrRead) stateNext.lsPend = 1'b0;
    if (chan.rxHeadErr && !stateReg.headSeen) stateNext.lsPend = 1'b1;
    stateNext.headSeen = chan.rxHeadErr;
    if (chan.rxErrArrive) stateNext.lsPend = 1'b1;

    // Transmit ready: below trigger once per reload, then empty
    if (chan.txCount >= txLvl && chan.txCount != 9'h000) stateNext.txOver = 1'b1;
    if (host.thrWrite || chan.txLoaded) begin
      stateNext.txBelowDone = 1'b0;
      stateNext.txEmptyDone = 1'b0;
    end
    if (isrRead && code == `UIC_CODE_TX) topServed = 1'b1;
    if (host.thrWrite || topServed) stateNext.txPend = 1'b0;
    if (!stateReg.fifoEn) begin
      if (chan.txCount == 9'h000 && !stateReg.txEmptyDone) begin
        stateNext.txPend = 1'b1;
        stateNext.txEmptyDone = 1'b1;
      end
    end else begin
      if (stateReg.txOver && chan.txCount < txLvl && !stateReg.txBelowDone) begin
        stateNext.txPend = 1'b1;
        stateNext.txBelowDone = 1'b1;
        stateNext.txOver = 1'b0;
      end
      if (txEmptyNow && !stateReg.txEmptyDone) begin
        stateNext.txPend = 1'b1;
        stateNext.txEmptyDone = 1'b1;
      end
    end

    // Modem and flow-pin changes clear on modem read
    if (host.msrRead) begin
      stateNext.msPend = 1'b0;
      stateNext.pinPend = 1'b0;
    end
    if (chan.modemDelta != 4'h0) stateNext.msPend = 1'b1;
    if (stateReg.enhanced_function_reg[`UIC_EFR_AUTOCTS] && stateReg.irq_enable_mask[`UIC_IER_CTS]) begin
      pinHit = pinHit | (dtrSel ? pinRise[0] : pinRise[2]);
    end
    if (stateReg.enhanced_function_reg[`UIC_EFR_AUTORTS] && stateReg.irq_enable_mask[`UIC_IER_RTS]) begin
      pinHit = pinHit | (dtrSel ? pinRise[1] : pinRise[3]);
    end
    if (pinHit) stateNext.pinPend = 1'b1;

    // Special character clears on status read
    // Only the reported source is acknowledged by a status read
    if (isrRead && code == `UIC_CODE_SPC) stateNext.spPend = 1'b0;
    if (chan.specialChar) stateNext.spPend = 1'b1;

    // Wake-up indication
    if (host.globalRead) stateNext.wake = 1'b0;
    if (chan.wakeUp) stateNext.wake = 1'b1;

    // Receive timeout: restarts on every char or read, counts bit ticks
    if (host.rhrRead) stateNext.toPend = 1'b0;
    case (stateReg.toState)
      TO_IDLE: begin
        if (chan.rxCount != 9'h000) begin
          stateNext.toState = TO_RUN;
          stateNext.toBits = 8'h00;
        end
      end
      TO_RUN: begin
        if (chan.rxCount == 9'h000) begin
          stateNext.toState = TO_IDLE;
        end else if (chan.rxCharDone || host.rhrRead) begin
          stateNext.toBits = 8'h00;
        end else if (chan.bitTick) begin
          stateNext.toBits = stateReg.toBits + 8'h01;
          if (stateReg.toBits ==
              `UIC_TO_CHARS * `UIC_BITS_PER_CHAR + `UIC_TO_BITS - 8'h01) begin
            stateNext.toState = TO_FIRE;
          end
        end
      end
      TO_FIRE: begin
        stateNext.toPend = 1'b1;
        stateNext.toState = TO_IDLE;
      end
      default: stateNext.toState = TO_IDLE;
    endcase

    // Read data decoded combinationally in the access cycle
    stateNext.rdata = 32'h0000_0000;
    if (setupRd) begin
      case (apbReq.paddr)
        `UIC_ADDR_IER: stateNext.rdata = {24'h000000, stateReg.irq_enable_mask};
        `UIC_ADDR_ISR: begin
          stateNext.rdata = {24'h000000, {2{stateReg.fifoEn}}, code};
        end
        `UIC_ADDR_FEATURE_CONTROL_REG: stateNext.rdata = {24'h000000, stateReg.feature_control_reg};
        `UIC_ADDR_EFR: stateNext.rdata = {24'h000000, stateReg.enhanced_function_reg};
        `UIC_ADDR_MCR: stateNext.rdata = {24'h000000, stateReg.modem_control_reg};
        `UIC_ADDR_EVT: stateNext.rdata = {7'h00, stateReg.txProg, 7'h00, stateReg.rxProg};
        `UIC_ADDR_STAT: begin
          stateNext.rdata = {20'h00000, stateReg.dma, stateReg.wake, stateReg.pinPend,
            stateReg.spPend, stateReg.msPend, stateReg.txPend, stateReg.toPend,
            stateReg.lsPend, rxDataPending, stateReg.trigTable, stateReg.fifoEn};
        end
        default: stateNext.rdata = 32'h0000_0000;
      endcase
    end

    // Line flags: per-char errors only for the head character
    stateNext.lsrView = {chan.rxFifoHasErr, 3'b000, chan.rxHeadErr, 3'b000};
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stateReg <= '0;
      stateReg.toState <= TO_IDLE;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Read data is combinational in the access cycle, so no wait states
  always_comb begin
    apbRsp.prdata = stateNext.rdata;
    apbRsp.pready = 1'b1;
    apbRsp.pslverr = 1'b0;
  end

  assign fifoEnable = stateReg.fifoEn;
  assign txFifoReset = stateReg.txRst & stateReg.fifoEn;
  assign rxFifoReset = stateReg.rxRst & stateReg.fifoEn;
  assign rxTrigLevel = rxLvl;
  assign txTrigLevel = txLvl;
  assign lineErrFlags = stateReg.lsrView;
  assign irqOut = anyPending;
  assign globalIrqSummary = stateReg.wake;
endmodule

// *** bench/uic_irq_ctrl_checker.sv ***
// Port-level assertions for the interrupt and queue control block
`timescale 1ns/100ps
`include "uic_cfg.svh"
module uic_irq_ctrl_checker import uic_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Bus and channel
  input wire uic_apb_req_t apbReq,
  input wire uic_apb_rsp_t apbRsp,
  input wire uic_chan_t chan,
  input wire uic_host_t host,
  // Block outputs
  input wire logic fifoEnable,
  input wire logic txFifoReset,
  input wire logic rxFifoReset,
  input wire logic [8:0] rxTrigLevel,
  input wire logic [8:0] txTrigLevel,
  input wire logic [7:0] lineErrFlags,
  input wire logic irqOut,
  input wire logic globalIrqSummary
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Shadow of the enables, since the mask is not visible at the ports
  logic [7:0] ier_reg;
  logic wrSeen_reg;
  wire acc = apbReq.psel && apbReq.penable;
  wire wr = acc && apbReq.pwrite;
  wire isrRd = acc && !apbReq.pwrite && apbReq.paddr == `UIC_ADDR_ISR;
  wire fcrWr = wr && apbReq.paddr == `UIC_ADDR_FCR;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ier_reg <= 8'h00;
      wrSeen_reg <= 1'b0;
    end else begin
      if (wr)
        wrSeen_reg <= 1'b1;
      if (wr && apbReq.paddr == `UIC_ADDR_IER)
        ier_reg <= apbReq.pwdata[7:0];
    end
  end
  property p_isr_pend;
    isrRd |-> apbRsp.prdata[0] == !irqOut;
  endproperty
  a_isr_pend: assert property (p_isr_pend) else $error("pending bit disagrees with irq");
  property p_isr_fifo;
    isrRd |-> apbRsp.prdata[7:6] == {2{fifoEnable}};
  endproperty
  a_isr_fifo: assert property (p_isr_fifo) else $error("status top bits wrong");
  property p_tx_rst;
    fcrWr && apbReq.pwdata[0] && apbReq.pwdata[2] |=> txFifoReset ##1 !txFifoReset;
  endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("tx reset pulse wrong");
  property p_rx_rst;
    fcrWr && apbReq.pwdata[0] && apbReq.pwdata[1] |=> rxFifoReset ##1 !rxFifoReset;
  endproperty
  a_rx_rst: assert property (p_rx_rst) else $error("rx reset pulse wrong");
  property p_no_rst;
    fcrWr && !apbReq.pwdata[0] |=> !txFifoReset && !rxFifoReset && !fifoEnable;
  endproperty
  a_no_rst: assert property (p_no_rst) else $error("disabled write acted");
  property p_def_lvl;
    !wrSeen_reg |-> rxTrigLevel == `UIC_LVL_DEFAULT && txTrigLevel == `UIC_LVL_DEFAULT;
  endproperty
  a_def_lvl: assert property (p_def_lvl) else $error("default levels wrong");
  property p_ls;
    chan.rxErrArrive && ier_reg[`UIC_IER_LS] |=> irqOut;
  endproperty
  a_ls: assert property (p_ls) else $error("line status irq missing");
  property p_ms;
    chan.modemDelta != 4'h0 && ier_reg[`UIC_IER_MS] |=> irqOut;
  endproperty
  a_ms: assert property (p_ms) else $error("modem irq missing");
  property p_wake;
    chan.wakeUp |=> globalIrqSummary;
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag missing");
  property p_wake_clr;
    globalIrqSummary && host.globalRead && !chan.wakeUp |=> !globalIrqSummary;
  endproperty
  a_wake_clr: assert property (p_wake_clr) else $error("wake flag not cleared");
  property p_fifo_err;
    chan.rxFifoHasErr && !chan.rxHeadErr |=> lineErrFlags[7] && !lineErrFlags[3];
  endproperty
  a_fifo_err: assert property (p_fifo_err) else $error("error flags wrong");
  c_timeout: cover property (isrRd && apbRsp.prdata[5:0] == `UIC_CODE_RXTO);
  c_line: cover property (isrRd && apbRsp.prdata[5:0] == `UIC_CODE_LS);
  c_txrst: cover property (txFifoReset);
endmodule

// *** bench/uic_chan_model.sv ***
// Behavioural channel datapath: receive count, bit tick, pass-through events
`timescale 1ns/100ps
module uic_chan_model import uic_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Stimulus and controls
  input wire uic_chan_t chanIn,
  input wire logic rxPush,
  input wire logic rhrRead,
  input wire logic rxFifoReset,
  // Toward the block
  output uic_chan_t chan
);
  logic [8:0] rxCnt_reg;
  logic [1:0] tick_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxCnt_reg <= 9'h000;
      tick_reg <= 2'h0;
    end else begin
      tick_reg <= tick_reg + 2'h1;
      if (rxFifoReset)
        rxCnt_reg <= 9'h000;
      else if (rxPush && !rhrRead)
        rxCnt_reg <= rxCnt_reg + 9'h001;
      else if (rhrRead && !rxPush && rxCnt_reg != 9'h000)
        rxCnt_reg <= rxCnt_reg - 9'h001;
    end
  end
  // Bit time of four clocks keeps the timeout run short
  always_comb begin
    chan = chanIn;
    chan.rxCount = rxCnt_reg;
    chan.rxCharDone = rxPush;
    chan.bitTick = tick_reg == 2'h0;
  end
endmodule

// *** bench/uic_irq_ctrl_tb.sv ***
// Self-checking testbench for the interrupt and queue control block
`timescale 1ns/100ps
`include "uic_cfg.svh"
module uic_irq_ctrl_tb import uic_pkg::*;;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  uic_apb_req_t apbReq = '0;
  uic_apb_rsp_t apbRsp;
  uic_chan_t chanIn = '0;
  uic_chan_t chan;
  uic_host_t host = '0;
  logic rxPush = 1'b0;
  logic fifoEnable, txFifoReset, rxFifoReset, irqOut, globalIrqSummary;
  logic [8:0] rxTrigLevel, txTrigLevel;
  logic [7:0] lineErrFlags;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  uic_irq_ctrl uic_irq_ctrl_i (.ref_clk(ref_clk), .nrst(nrst), .apbReq(apbReq),
    .apbRsp(apbRsp), .chan(chan), .host(host), .fifoEnable(fifoEnable),
    .txFifoReset(txFifoReset), .rxFifoReset(rxFifoReset), .rxTrigLevel(rxTrigLevel),
    .txTrigLevel(txTrigLevel), .lineErrFlags(lineErrFlags), .irqOut(irqOut),
    .globalIrqSummary(globalIrqSummary));
  uic_chan_model uic_chan_model_i (.ref_clk(ref_clk), .nrst(nrst), .chanIn(chanIn),
    .rxPush(rxPush), .rhrRead(host.rhrRead), .rxFifoReset(rxFifoReset), .chan(chan));
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      summarize();
    end
  end
  task automatic summarize();
    if (fails == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge ref_clk);
    apbReq.psel <= 1'b1;
    apbReq.pwrite <= w;
    apbReq.paddr <= a;
    apbReq.pwdata <= d;
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    @(posedge ref_clk);
    while (apbRsp.pready !== 1'b1)
      @(posedge ref_clk);
    r = apbRsp.prdata;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic hp(input logic [4:0] v);
    @(posedge ref_clk);
    host <= uic_host_t'(v);
    @(posedge ref_clk);
    host <= '0;
  endtask
  task automatic cp(input uic_chan_t v);
    @(posedge ref_clk);
    chanIn <= v;
    @(posedge ref_clk);
    chanIn <= '0;
  endtask
  task automatic t_reset();
    rd(`UIC_ADDR_ISR, 32'h01);
    rd(`UIC_ADDR_IER, 32'h00);
    rd(12'hFF0, 32'h00);
    @(negedge ref_clk);
    chk(32'(irqOut), 32'h0);
  endtask
  task automatic t_fifo();
    logic [8:0] lvA [4] = '{9'h001, 9'h004, 9'h008, 9'h00E};
    wr(`UIC_ADDR_FCR, 32'h07);
    @(negedge ref_clk);
    chk(32'({txFifoReset, rxFifoReset, fifoEnable}), 32'h7);
    @(negedge ref_clk);
    chk(32'({txFifoReset, rxFifoReset}), 32'h0);
    rd(`UIC_ADDR_ISR, 32'hC1);
    // Mode bit set in every write; rxSel steps the receive level through table 0, transmit level stays at 1
    for (int i = 0; i < 4; i++) begin
      wr(`UIC_ADDR_FCR, 32'(i * 64 + 9));
      @(negedge ref_clk);
      chk(32'({rxTrigLevel, txTrigLevel}), 32'({lvA[i], 9'h001}));
    end
    wr(`UIC_ADDR_FCR, 32'h06);
    @(negedge ref_clk);
    chk(32'({txFifoReset, fifoEnable}), 32'h0);
    rd(`UIC_ADDR_ISR, 32'h01);
    wr(`UIC_ADDR_EFR, 32'h10);
    wr(`UIC_ADDR_FEATURE_CONTROL_REG, 32'h40);
    wr(`UIC_ADDR_FCR, 32'hF1);
    @(negedge ref_clk);
    chk(32'({rxTrigLevel, txTrigLevel}), 32'({9'h01C, 9'h01E}));
    wr(`UIC_ADDR_FEATURE_CONTROL_REG, 32'h00);
    @(negedge ref_clk);
    chk(32'({rxTrigLevel, txTrigLevel}), 32'({9'h00E, 9'h001}));
    wr(`UIC_ADDR_FCR, 32'h41);
  endtask
  task automatic t_prio();
    uic_chan_t v;
    v = '0;
    v.rxErrArrive = 1'b1;
    v.modemDelta = 4'h1;
    wr(`UIC_ADDR_IER, 32'h0D);
    repeat (4) begin
      @(posedge ref_clk);
      rxPush <= 1'b1;
      @(posedge ref_clk);
      rxPush <= 1'b0;
    end
    cp(v);
    @(posedge ref_clk);
    chanIn.rxFifoHasErr <= 1'b1;
    @(negedge ref_clk);
    @(negedge ref_clk);
    chk(32'({lineErrFlags[7], lineErrFlags[3]}), 32'h2);
    chk(32'(irqOut), 32'h1);
    @(posedge ref_clk);
    chanIn.rxFifoHasErr <= 1'b0;
    rd(`UIC_ADDR_ISR, 32'hC6);
    rd(`UIC_ADDR_ISR, 32'hC6);
    hp(5'h10);
    rd(`UIC_ADDR_ISR, 32'hC4);
    @(posedge ref_clk);
    chanIn.rxHeadErr <= 1'b1;
    rd(`UIC_ADDR_ISR, 32'hC6);
    chanIn.rxHeadErr <= 1'b0;
    hp(5'h10);
    hp(5'h04);
    rd(`UIC_ADDR_ISR, 32'hC0);
    hp(5'h08);
    rd(`UIC_ADDR_ISR, 32'hC1);
  endtask
  task automatic t_timeout();
    // 52 bit times of 4 clocks each after the last receive read
    repeat (140) @(posedge ref_clk);
    rd(`UIC_ADDR_ISR, 32'hC1);
    repeat (100) @(posedge ref_clk);
    rd(`UIC_ADDR_ISR, 32'hCC);
    hp(5'h04);
    rd(`UIC_ADDR_ISR, 32'hC1);
    wr(`UIC_ADDR_FCR, 32'h03);
    @(negedge ref_clk);
    @(negedge ref_clk);
    chk(32'(chan.rxCount), 32'h0);
    wr(`UIC_ADDR_IER, 32'h00);
  endtask
  task automatic t_misc();
    uic_chan_t v;
    wr(`UIC_ADDR_FCR, 32'h00);
    wr(`UIC_ADDR_IER, 32'h02);
    rd(`UIC_ADDR_ISR, 32'h02);
    rd(`UIC_ADDR_ISR, 32'h01);
    wr(`UIC_ADDR_EFR, 32'h90);
    wr(`UIC_ADDR_IER, 32'hA0);
    v = '0;
    v.specialChar = 1'b1;
    cp(v);
    rd(`UIC_ADDR_ISR, 32'h10);
    rd(`UIC_ADDR_ISR, 32'h01);
    @(posedge ref_clk);
    chanIn.ctsLine <= 1'b1;
    rd(`UIC_ADDR_ISR, 32'h20);
    hp(5'h08);
    rd(`UIC_ADDR_ISR, 32'h01);
    v = '0;
    v.wakeUp = 1'b1;
    cp(v);
    @(negedge ref_clk);
    chk(32'(globalIrqSummary), 32'h1);
    hp(5'h01);
    @(negedge ref_clk);
    chk(32'(globalIrqSummary), 32'h0);
  endtask
  task automatic t_tx();
    wr(`UIC_ADDR_FEATURE_CONTROL_REG, 32'h60);
    wr(`UIC_ADDR_FCR, 32'h01);
    wr(`UIC_ADDR_IER, 32'h02);
    // Reload above the level of 16, then drain below it
    @(posedge ref_clk);
    chanIn.txCount <= 9'h014;
    chanIn.txLoaded <= 1'b1;
    @(posedge ref_clk);
    chanIn.txLoaded <= 1'b0;
    chanIn.txCount <= 9'h00A;
    rd(`UIC_ADDR_ISR, 32'hC2);
    rd(`UIC_ADDR_ISR, 32'hC1);
    // Half duplex: empty queue alone must not raise the second one
    @(posedge ref_clk);
    chanIn.txCount <= 9'h000;
    rd(`UIC_ADDR_ISR, 32'hC1);
    @(posedge ref_clk);
    chanIn.txShiftEmpty <= 1'b1;
    @(negedge ref_clk);
    @(negedge ref_clk);
    chk(32'(irqOut), 32'h1);
    @(posedge ref_clk);
    host.thrWrite <= 1'b1;
    chanIn.txCount <= 9'h005;
    @(posedge ref_clk);
    host.thrWrite <= 1'b0;
    rd(`UIC_ADDR_ISR, 32'hC1);
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_fifo();
    t_prio();
    t_timeout();
    t_misc();
    t_tx();
    summarize();
  end
endmodule
bind uic_irq_ctrl uic_irq_ctrl_checker uic_irq_ctrl_checker_i (.ref_clk(ref_clk),
  .nrst(nrst), .apbReq(apbReq), .apbRsp(apbRsp), .chan(chan), .host(host),
  .fifoEnable(fifoEnable), .txFifoReset(txFifoReset), .rxFifoReset(rxFifoReset),
  .rxTrigLevel(rxTrigLevel), .txTrigLevel(txTrigLevel), .lineErrFlags(lineErrFlags),
  .irqOut(irqOut), .globalIrqSummary(globalIrqSummary));
